// >>> rtl/bsfr_bank1.v
// bank 1 special register map, reached over an AHB-Lite slave port
// assumes: one 100 MHz clock, word transfers only, cause pins asynchronous
//
// Overview of operation
// [R1] Unimplemented locations and unimplemented bits read back as zero.
// [R2] Each bit on reset keeps, clears, sets or takes a cause value.
// [R3] Shared registers answer at the same offset in bank 0 and bank 1.
// [R4] No register gives direct access to the program counter upper byte.
// [R5] The five-bit high latch is copied into PC bits 12 to 8 on a load.
// [R6] Pin and watchdog resets use the other-reset values, the rest power-up.
// [R7] Software keeps the indirect and upper direct bank select bits clear.
// [R8] Writes to unimplemented locations or bits change nothing at all.
`timescale 1ns/1ns
`include "bsfr_regs.vh"
module bsfr_bank1 (
	clk,
	reset_n,
	clkEnable,
	hsel,
	haddr,
	htrans,
	hwrite,
	hsize,
	hwdata,
	hready,
	hrdata,
	hreadyout,
	hresp,
	causePowerUp,
	causeBrownout,
	causeParity,
	causeWatchdog,
	causeSleep,
	parityEnable,
	pcStep,
	programCounter,
	timerOption,
	portADirection,
	portBDirection,
	bankSelect,
	interruptEnable,
	adcIrqEnable,
	adcPortConfig
);
	input  wire                       clk;
	input  wire                       reset_n;
	input  wire                       clkEnable;
	input  wire                       hsel;
	input  wire [31:0]                haddr;
	input  wire [1:0]                 htrans;
	input  wire                       hwrite;
	input  wire [2:0]                 hsize;
	input  wire [31:0]                hwdata;
	input  wire                       hready;
	output reg  [31:0]                hrdata;
	output reg                        hreadyout;
	output reg                        hresp;
	input  wire                       causePowerUp;
	input  wire                       causeBrownout;
	input  wire                       causeParity;
	input  wire                       causeWatchdog;
	input  wire                       causeSleep;
	input  wire                       parityEnable;
	input  wire                       pcStep;
	output reg  [`BSFR_PC_W-1:0]      programCounter;
	output reg  [7:0]                 timerOption;
	output reg  [`BSFR_PORT_A_DIRECTION_W-1:0]   portADirection;
	output reg  [7:0]                 portBDirection;
	output reg                        bankSelect;
	output reg  [4:0]                 interruptEnable;
	output reg                        adcIrqEnable;
	output reg  [`BSFR_ADCCFG_W-1:0]  adcPortConfig;

	// storage that has no output of its own
	reg  [`BSFR_PCH_W-1:0]    pcHighLatch;
	reg  [1:0]                bankReserved;   // indirect and high select
	reg  [2:0]                aluFlags;       // zero, digit carry, carry
	reg                       timeoutFlag;
	reg                       powerDownFlag;
	reg  [7:0]                indirectPointer;
	reg  [1:0]                intEdgeFlags;   // interrupt control bits 2:1
	reg                       intPortFlag;    // interrupt control bit 0
	reg                       parityResetFlag;
	reg                       powerOnFlag;
	reg                       brownoutFlag;
	reg  [1:0]                initWait;

	// bus state
	reg                       pending;
	reg                       pendWrite;
	reg                       pendMapped;
	reg  [7:0]                pendIndex;

	wire [`BSFR_CAUSE_W-1:0]  causeSync;
	wire                      syncPowerUp;
	wire                      syncBrownout;
	wire                      syncParity;
	wire                      syncWatchdog;
	wire                      syncSleep;
	wire                      syncParityEn;
	wire                      powerUpClass;
	wire                      accept;
	wire                      complete;
	wire [7:0]                directIndex;
	wire [7:0]                targetIndex;
	wire [7:0]                wrByte;
	wire                      doWrite;

	bsfr_sync causeSyncer (
		.clk     (clk),
		.reset_n (reset_n),
		.asyncIn ({parityEnable, causeSleep, causeWatchdog,
			causeParity, causeBrownout, causePowerUp}),
		.syncOut (causeSync)
	);

	assign syncPowerUp  = causeSync[0];
	assign syncBrownout = causeSync[1];
	assign syncParity   = causeSync[2];
	assign syncWatchdog = causeSync[3];
	assign syncSleep    = causeSync[4];
	assign syncParityEn = causeSync[5];
	// power-on, brown-out and parity resets share the power-up values
	assign powerUpClass = syncPowerUp | syncBrownout | syncParity; // [R6]

	// bank 0 aliases of the shared registers fold onto bank 1
	function [7:0] mapIndex;
		input [7:0] idx;
		reg   [7:0] folded;
		begin
			folded = idx | `BSFR_BANK1_SET;
			mapIndex = idx;
			if (!idx[`BSFR_BANK_BIT]) begin
				case (folded)
				`BSFR_IDX_INDIRECT, `BSFR_IDX_PCLOW,
				`BSFR_IDX_STATUS, `BSFR_IDX_POINTER,
				`BSFR_IDX_PCHIGH, `BSFR_IDX_INTCTRL:
					mapIndex = folded;             // [R3]
				default:
					mapIndex = idx;
				endcase
			end
		end
	endfunction

	// read value of one mapped index; anything else reads zero
	function [7:0] readIndex;
		input [7:0] idx;
		begin
			case (idx)
			`BSFR_IDX_OPTION:  readIndex = timerOption;
			`BSFR_IDX_PCLOW:   readIndex = programCounter[7:0];
			`BSFR_IDX_STATUS:  readIndex = {bankReserved, bankSelect,
				timeoutFlag, powerDownFlag, aluFlags};
			`BSFR_IDX_POINTER: readIndex = indirectPointer;
			`BSFR_IDX_PORT_A_DIRECTION:   readIndex = {2'h0, portADirection}; // [R1]
			`BSFR_IDX_PORT_B_DIRECTION:   readIndex = portBDirection;
			`BSFR_IDX_PCHIGH:  readIndex = {3'h0, pcHighLatch};   // [R1]
			`BSFR_IDX_INTCTRL: readIndex = {interruptEnable,
				intEdgeFlags, intPortFlag};
			`BSFR_IDX_PIE:     readIndex = {1'b0, adcIrqEnable, 6'h00};
			`BSFR_IDX_PWRSTAT: readIndex = {syncParityEn, 4'h0,
				parityResetFlag, powerOnFlag, brownoutFlag};
			`BSFR_IDX_ADCCFG:  readIndex = {6'h00, adcPortConfig};
			// no index reaches the upper program counter byte [R4]
			default:           readIndex = `BSFR_RST_BYTE;  // [R1]
			endcase
		end
	endfunction

	assign accept = hsel & hready & hreadyout & (htrans == `BSFR_HTRANS_NSEQ);
	assign directIndex = mapIndex(haddr[`BSFR_ADDR_IDX_HI:`BSFR_ADDR_IDX_LO]);
	// the indirect port steers to whatever the pointer names
	assign targetIndex = (pendIndex == `BSFR_IDX_INDIRECT) ?
		mapIndex(indirectPointer) : pendIndex;
	assign complete = pending & clkEnable & (initWait == `BSFR_INIT_DONE);
	assign wrByte   = hwdata[7:0];
	// an unmapped address or a pointer back at the port writes nothing
	assign doWrite  = complete & pendWrite & pendMapped; // [R8]

	// address phase capture; runs unfrozen so no transfer is dropped
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pending    <= 1'b0;
			pendWrite  <= 1'b0;
			pendMapped <= 1'b0;
			pendIndex  <= `BSFR_RST_BYTE;
			hreadyout  <= 1'b1;
			hrdata     <= 32'h00000000;
			hresp      <= 1'b0;
		end else if (accept) begin
			pending    <= 1'b1;
			pendWrite  <= hwrite;
			pendMapped <= ~|haddr[31:`BSFR_ADDR_TOP_LO];
			pendIndex  <= directIndex;
			hreadyout  <= 1'b0;                    // one wait state
		end else if (complete) begin
			pending    <= 1'b0;
			hreadyout  <= 1'b1;
			hrdata     <= {`BSFR_RDATA_PAD, (pendMapped && !pendWrite) ?
				readIndex(targetIndex) : `BSFR_RST_BYTE};
		end
	end

	// waits for the cause pins to pass the synchroniser
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			initWait <= `BSFR_INIT_WAIT;
		end else if (clkEnable && initWait != `BSFR_INIT_DONE) begin
			initWait <= initWait - `BSFR_INIT_STEP;
		end
	end

	// bits with a fixed value on every reset
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timerOption     <= `BSFR_RST_OPTION;       // [R2]
			portADirection  <= `BSFR_RST_PORT_A_DIRECTION;
			portBDirection  <= `BSFR_RST_PORT_B_DIRECTION;
			pcHighLatch     <= `BSFR_RST_PCH;
			programCounter  <= `BSFR_RST_PC;
			{bankReserved, bankSelect} <= `BSFR_RST_BANKSEL;
			{interruptEnable, intEdgeFlags} <= `BSFR_RST_INTEN;
			adcIrqEnable    <= 1'b0;
			adcPortConfig   <= `BSFR_RST_ADCCFG;
			parityResetFlag <= 1'b1;
		end else if (clkEnable) begin
			if (doWrite) begin
				case (targetIndex)
				`BSFR_IDX_OPTION:  timerOption <= wrByte;
				`BSFR_IDX_PORT_A_DIRECTION:
					portADirection <= wrByte[`BSFR_PORT_A_DIRECTION_W-1:0]; // [R8]
				`BSFR_IDX_PORT_B_DIRECTION:   portBDirection <= wrByte;
				`BSFR_IDX_PCHIGH:
					pcHighLatch <= wrByte[`BSFR_PCH_W-1:0];    // [R5]
				`BSFR_IDX_STATUS: begin
					// reserved select bits stored as written [R7]
					bankReserved <= wrByte[`BSFR_ST_IRP:`BSFR_ST_RP1];
					bankSelect   <= wrByte[`BSFR_ST_RP0];
				end
				`BSFR_IDX_INTCTRL:
					{interruptEnable, intEdgeFlags} <= wrByte[7:1];
				`BSFR_IDX_PIE:     adcIrqEnable <= wrByte[`BSFR_PIE_ADIE];
				`BSFR_IDX_PWRSTAT:
					parityResetFlag <= wrByte[`BSFR_PWR_PER];
				`BSFR_IDX_ADCCFG:
					adcPortConfig <= wrByte[`BSFR_ADCCFG_W-1:0];
				default: ;                                   // [R8]
				endcase
			end
			// a low byte write loads the whole PC: bits 12 to 8 from the latch, 7 to 0 from the byte
			if (doWrite && targetIndex == `BSFR_IDX_PCLOW) begin
				programCounter <= {pcHighLatch, wrByte};     // [R5]
			end else if (pcStep) begin
				programCounter <= programCounter + `BSFR_RST_PC + 1'b1;
			end
		end
	end

	// time-out and power-down: set on every reset, then cause dependent
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timeoutFlag   <= 1'b1;
			powerDownFlag <= 1'b1;
		end else if (clkEnable && initWait == `BSFR_INIT_STEP) begin
			if (!powerUpClass) begin                        // [R6]
				timeoutFlag   <= ~syncWatchdog;             // [R2]
				powerDownFlag <= ~syncSleep;
			end
		end
	end

	// bits left unchanged by pin and watchdog resets: no async reset,
	// so the value before the reset survives it
	always @(posedge clk) begin
		if (clkEnable) begin
			if (initWait == `BSFR_INIT_STEP) begin
				if (powerUpClass) begin                     // [R6]
					// unknown bits settle to zero, the power-on and brown-out bits each clear for their own cause and set otherwise
					{aluFlags} <= `BSFR_PWRUP_ZERO;         // [R2]
					indirectPointer <= `BSFR_RST_BYTE;
					intPortFlag     <= 1'b0;
					powerOnFlag     <= ~syncPowerUp;
					brownoutFlag    <= ~syncBrownout;
				end
			end else if (doWrite) begin
				case (targetIndex)
				`BSFR_IDX_STATUS:
					aluFlags <= wrByte[2:0];
				`BSFR_IDX_POINTER:
					indirectPointer <= wrByte;
				`BSFR_IDX_INTCTRL:
					intPortFlag <= wrByte[0];
				`BSFR_IDX_PWRSTAT: begin
					powerOnFlag  <= wrByte[`BSFR_PWR_POR];
					brownoutFlag <= wrByte[`BSFR_PWR_BOR];
				end
				default: ;
				endcase
			end
		end
	end
endmodule

// >>> rtl/bsfr_regs.vh
// constants for the bank 1 special register map
// assumes: included by the bank and its synchroniser, definitions only
`ifndef BSFR_REGS_VH
`define BSFR_REGS_VH

// register indices; byte address on the bus is four times the index
`define BSFR_IDX_INDIRECT  8'h80
`define BSFR_IDX_OPTION    8'h81
`define BSFR_IDX_PCLOW     8'h82
`define BSFR_IDX_STATUS    8'h83
`define BSFR_IDX_POINTER   8'h84
`define BSFR_IDX_PORT_A_DIRECTION     8'h85
`define BSFR_IDX_PORT_B_DIRECTION     8'h86
`define BSFR_IDX_PCHIGH    8'h8A
`define BSFR_IDX_INTCTRL   8'h8B
`define BSFR_IDX_PIE       8'h8C
`define BSFR_IDX_PWRSTAT   8'h8E
`define BSFR_IDX_ADCCFG    8'h9F

// bank select bit within an index; clearing it gives the bank 0 alias
`define BSFR_BANK_BIT      7
`define BSFR_BANK1_SET     8'h80

// bus address slicing
`define BSFR_ADDR_IDX_HI   9
`define BSFR_ADDR_IDX_LO   2
`define BSFR_ADDR_TOP_LO   10
`define BSFR_RDATA_PAD     24'h000000
`define BSFR_HTRANS_NSEQ   2'h2

// field widths
`define BSFR_PORT_A_DIRECTION_W       6
`define BSFR_PCH_W         5
`define BSFR_PC_W          13
`define BSFR_ADCCFG_W      2

// field positions
`define BSFR_ST_IRP        7
`define BSFR_ST_RP1        6
`define BSFR_ST_RP0        5
`define BSFR_ST_TO         4
`define BSFR_ST_PD         3
`define BSFR_PWR_MPEEN     7
`define BSFR_PWR_PER       2
`define BSFR_PWR_POR       1
`define BSFR_PWR_BOR       0
`define BSFR_PIE_ADIE      6

// reset values
`define BSFR_RST_OPTION    8'hFF
`define BSFR_RST_PORT_A_DIRECTION     6'h3F
`define BSFR_RST_PORT_B_DIRECTION     8'hFF
`define BSFR_RST_BYTE      8'h00
`define BSFR_RST_PC        13'h0000
`define BSFR_RST_PCH       5'h00
`define BSFR_RST_BANKSEL   3'h0
`define BSFR_RST_INTEN     7'h00
`define BSFR_RST_ADCCFG    2'h0
`define BSFR_PWRUP_ZERO    3'h0

// cause pins: synchroniser width and the wait before causes are applied;
// the wait spans both sync stages so the applying edge sees the real pins
`define BSFR_CAUSE_W       6
`define BSFR_INIT_WAIT     2'h3
`define BSFR_INIT_DONE     2'h0
`define BSFR_INIT_STEP     2'h1

`endif

// >>> rtl/bsfr_sync.v
// two-flop synchroniser for the reset cause pins
// assumes: inputs asynchronous to clk; first stage read only by second
`timescale 1ns/1ns
`include "bsfr_regs.vh"
module bsfr_sync (
	clk,
	reset_n,
	asyncIn,
	syncOut
);
	input  wire                      clk;
	input  wire                      reset_n;
	input  wire [`BSFR_CAUSE_W-1:0]  asyncIn;
	output reg  [`BSFR_CAUSE_W-1:0]  syncOut;

	reg [`BSFR_CAUSE_W-1:0] firstStage;

	// runs without the clock enable so causes settle even while frozen
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			firstStage <= {`BSFR_CAUSE_W{1'b0}};
			syncOut    <= {`BSFR_CAUSE_W{1'b0}};
		end else begin
			firstStage <= asyncIn;
			syncOut    <= firstStage;
		end
	end
endmodule

// >>> tb/bsfr_bank1_properties.sv
// checker for the bus handshake and program counter ports of bank 1
// assumes: bound to bsfr_bank1, one clock, reset_n async active low
`timescale 1ns/1ns
`include "bsfr_regs.vh"
module bsfr_bank1_properties (
	input logic                   clk,
	input logic                   reset_n,
	input logic                   clkEnable,
	input logic                   hsel,
	input logic [1:0]             htrans,
	input logic                   hwrite,
	input logic                   hready,
	input logic [31:0]            hrdata,
	input logic                   hreadyout,
	input logic                   hresp,
	input logic                   pcStep,
	input logic [`BSFR_PC_W-1:0]  programCounter
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic taken;
	// a transfer is accepted only with the slave idle
	assign taken = hsel && hready && hreadyout && htrans == 2'h2;

	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_RDZ: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	AST_WAIT: assert property (taken |=> !hreadyout)
		else $error("no wait state after accept");
	AST_IDLE: assert property (hreadyout && !taken |=> hreadyout)
		else $error("wait state without transfer");
	AST_FREEZE: assert property (!hreadyout && !clkEnable |=> !hreadyout)
		else $error("completed while clock disabled");
	AST_DONE: assert property ($fell(hreadyout) && clkEnable |->
		##[1:3] hreadyout)
		else $error("transfer did not complete");
	AST_HOLD: assert property (hreadyout |=> $stable(hrdata))
		else $error("read data moved between completions");
	// pc moves only by one step per enabled cycle or by a load
	AST_PCSTEP: assert property (clkEnable && pcStep && hreadyout |=>
		programCounter == $past(programCounter) + 13'h1)
		else $error("pc did not step");
	AST_PCHOLD: assert property ((!clkEnable || !pcStep) && hreadyout
		|=> $stable(programCounter))
		else $error("pc changed without cause");

	cover property (taken && hwrite);
	cover property (clkEnable && pcStep);
	cover property (!hreadyout && !clkEnable);
endmodule

bind bsfr_bank1 bsfr_bank1_properties i_props (
	.clk(clk), .reset_n(reset_n), .clkEnable(clkEnable), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .pcStep(pcStep),
	.programCounter(programCounter)
);

// >>> tb/bsfr_bank1_tb.sv
// self-checking bench for the bank 1 register map
// assumes: the core model is the only master, 100 MHz clock
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
	fail_count++; $display("ERROR %0t: got %h want %h", $time, g, e); \
	end end
module bsfr_bank1_tb;
	logic         clk = 1'b0;
	logic         reset_n = 1'b0;
	logic         clkEnable = 1'b1;
	logic [4:0]   cause = 5'h10; // powerup brownout parity watchdog sleep
	logic         parityEnable = 1'b0;
	logic         pcStep = 1'b0;
	logic         hsel, hwrite, hreadyout, hresp, bankSelect, adcIrqEnable;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans, adcPortConfig;
	logic [2:0]   hsize;
	logic [12:0]  programCounter;
	logic [7:0]   timerOption, portBDirection, rd;
	logic [5:0]   portADirection;
	logic [4:0]   interruptEnable;
	int           fail_count = 0;
	int           compares = 0;
	int           cycles = 0;
	// write address, data, read address, expected read
	logic [39:0]  tbl [14] = '{40'h204A5204A5, 40'h214FF2143F,
		40'h2185A2185A, 40'h21CFF21C00, 40'h0280F2280F, 40'h22C8102C81,
		40'h230BF23000, 40'h27CFF27C03, 40'h238FF23887, 40'h2108C0108C,
		40'h200FF23040, 40'h20CFF00C3F, 40'h2083420834, 40'h220FF22000};
	logic [19:0]  rv [11] = '{20'h204FF, 20'h2143F, 20'h218FF, 20'h22800,
		20'h23000, 20'h27C00, 20'h20C18, 20'h23805, 20'h20800, 20'h20000,
		20'h22C00};
	// cause, then pointer, status, irq control, power status after reset
	logic [7:0]   rr [6][5] = '{'{0, 'h8C, 'h1F, 1, 4},
		'{2, 'h8C, 'h0F, 1, 4}, '{3, 'h8C, 'h07, 1, 4},
		'{'h10, 0, 'h18, 0, 5}, '{8, 0, 'h18, 0, 6}, '{4, 0, 'h18, 0, 7}};
	logic [11:0]  pa [4] = '{12'h210, 12'h20C, 12'h22C, 12'h238};
	logic [7:0]   pv [4] = '{8'h8C, 8'h07, 8'h01, 8'h00};

	always #5 clk = ~clk;

	bsfr_bank1 i_dut (.clk(clk), .reset_n(reset_n), .clkEnable(clkEnable),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.causePowerUp(cause[4]), .causeBrownout(cause[3]),
		.causeParity(cause[2]), .causeWatchdog(cause[1]),
		.causeSleep(cause[0]), .parityEnable(parityEnable),
		.pcStep(pcStep), .programCounter(programCounter),
		.timerOption(timerOption), .portADirection(portADirection),
		.portBDirection(portBDirection), .bankSelect(bankSelect),
		.interruptEnable(interruptEnable), .adcIrqEnable(adcIrqEnable),
		.adcPortConfig(adcPortConfig));
	bsfr_core_model i_core (.clk(clk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	task automatic stop_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// causes change only while reset is held, as the sync needs
	task automatic rst(input logic [4:0] c);
		@(posedge clk);
		reset_n <= 1'b0;
		cause <= c;
		repeat (12) @(posedge clk);
		`CHK({programCounter, timerOption, portADirection, portBDirection,
			bankSelect, interruptEnable, adcIrqEnable, adcPortConfig,
			hreadyout, hrdata}, {13'h0, 8'hFF, 6'h3F, 8'hFF, 1'b0, 5'h0,
			1'b0, 2'h0, 1'b1, 32'h0})
		reset_n <= 1'b1;
	endtask

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			stop_test;
		end
	end

	initial begin
		rst(5'h10);
		foreach (rv[i]) begin
			i_core.xfer({20'h0, rv[i][19:8]}, 1'b0, 8'h0, 0, rd);
			`CHK(rd, rv[i][7:0])
		end
		parityEnable <= 1'b1;
		foreach (tbl[i]) begin
			i_core.xfer({20'h0, tbl[i][39:28]}, 1'b1, tbl[i][27:20], i % 3, rd);
			i_core.xfer({20'h0, tbl[i][19:8]}, 1'b0, 8'h0, 0, rd);
			`CHK(rd, tbl[i][7:0])
		end
		`CHK({timerOption, portADirection, portBDirection, bankSelect,
			interruptEnable, adcIrqEnable, adcPortConfig, programCounter},
			{8'hA5, 6'h3F, 8'h5A, 1'b1, 5'h10, 1'b1, 2'h3, 13'h0F34})
		// top address bits set: reads zero, write lost
		i_core.xfer(32'h40000204, 1'b1, 8'h00, 0, rd);
		i_core.xfer(32'h40000204, 1'b0, 8'h00, 0, rd);
		`CHK(rd, 8'h00)
		`CHK(timerOption, 8'hA5)
		// pc steps only on enabled cycles: 2 + 3 of them here
		pcStep <= 1'b1;
		repeat (2) @(posedge clk);
		clkEnable <= 1'b0;
		repeat (3) @(posedge clk);
		clkEnable <= 1'b1;
		repeat (3) @(posedge clk);
		pcStep <= 1'b0;
		@(posedge clk);
		`CHK(programCounter, 13'h0F39)
		i_core.xfer(32'h228, 1'b1, 8'h05, 1, rd);
		`CHK(programCounter, 13'h0F39)
		i_core.xfer(32'h208, 1'b1, 8'h00, 0, rd);
		`CHK(programCounter, 13'h0500)
		// completion waits for the clock enable
		clkEnable <= 1'b0;
		fork
			i_core.xfer(32'h028, 1'b0, 8'h00, 0, rd);
			begin
				repeat (6) @(posedge clk);
				`CHK(hreadyout, 1'b0)
				clkEnable <= 1'b1;
			end
		join
		`CHK(rd, 8'h05)
		parityEnable <= 1'b0;
		foreach (rr[i]) begin
			foreach (pa[j])
				i_core.xfer({20'h0, pa[j]}, 1'b1, pv[j], 0, rd);
			rst(rr[i][0][4:0]);
			foreach (pa[j]) begin
				i_core.xfer({20'h0, pa[j]}, 1'b0, 8'h0, 0, rd);
				`CHK(rd, rr[i][j + 1])
			end
		end
		stop_test;
	end
endmodule

// >>> tb/bsfr_core_model.sv
// core model: single word reads and writes as the only bus master
// assumes: hready is the slave hreadyout, changes right after rising edge
`timescale 1ns/1ns
module bsfr_core_model (
	input  logic         clk,
	input  logic         hready,
	input  logic [31:0]  hrdata,
	output logic         hsel = 1'b0,
	output logic [31:0]  haddr = 32'h0,
	output logic [1:0]   htrans = 2'h0,
	output logic         hwrite = 1'b0,
	output logic [2:0]   hsize = 3'h2,
	output logic [31:0]  hwdata = 32'h0
);
	// released lines show the inverse so stale values never match
	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [7:0] d, input int gap, output logic [7:0] r);
		logic [7:0] v;
		v = d;
		if (w && a[8:0] == 9'h00C)
			v[7:6] = 2'h0;
		repeat (gap) @(posedge clk);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= {24'h0, v};
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata[7:0];
		hwdata <= ~{24'h0, v};
		hwrite <= ~w;
	endtask
endmodule
